/* pkg/fmg_pkg.sv */
// Purpose: Shared constants and types for the fault mask, output pin and discharge bank.
// Assumes: Byte-wide registers reached over the two-wire serial host port.
// Notes: Fault vector layout is fixed here and used by the bank and the fault gate.
package fmg_pkg;

  // Register offsets on the serial port.
  localparam logic [7:0] OFS_PIN_CTRL = 8'ha1;
  localparam logic [7:0] OFS_MASK_FIRST = 8'ha2;
  localparam logic [7:0] OFS_MASK_SECOND = 8'ha3;
  localparam logic [7:0] OFS_DISCH = 8'had;

  // Reset values.
  localparam logic [7:0] RST_PIN_CTRL = 8'h20;
  localparam logic [7:0] RST_MASK_FIRST = 8'hc0;
  localparam logic [7:0] RST_MASK_SECOND = 8'h37;
  localparam logic [7:0] RST_DISCH = 8'h61;

  // Writable bits; the top bit of the second mask register is read only.
  localparam logic [7:0] WMASK_ALL = 8'hff;
  localparam logic [7:0] WMASK_SECOND = 8'h7f;

  // Field positions.
  localparam int BIT_PIN_LEVEL = 5;
  localparam int BIT_TERM_DISCH = 4;
  localparam int BIT_ADJ2_MASK = 7;
  localparam int BIT_LSW1_MASK = 6;
  localparam int BIT_ANALOG5_MASK = 5;
  localparam int BIT_ADJ1_MASK = 4;
  localparam int BIT_TERM_MASK = 3;
  localparam int BIT_PAIR_HI = 2;
  localparam int BIT_PAIR_LO = 1;
  localparam int BIT_ADJ3_MASK = 0;
  localparam int BIT_SECOND_RO = 7;
  localparam logic [1:0] PAIR_MASKED = 2'h3;

  // Fault vector: bits 7..0 follow the first mask register, then the rails below.
  localparam int NUM_RAILS = 13;
  localparam int FLT_ADJ3 = 8;
  localparam int FLT_PAIR = 9;
  localparam int FLT_TERM = 10;
  localparam int FLT_ADJ1 = 11;
  localparam int FLT_ANALOG5 = 12;

  // Serial target address; the value is arbitrary.
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_ADDR_ACK = 9'h004,
    ST_PTR = 9'h008,
    ST_PTR_ACK = 9'h010,
    ST_WDATA = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA = 9'h080,
    ST_RDATA_ACK = 9'h100
  } fmg_state_t;

endpackage

/* hw/fmg_byte_reg.sv */
// Purpose: One byte-wide software register with a reset value and a writable-bit mask.
// Assumes: Write strobe is a one-cycle pulse from the serial front end.
// Notes: Bits outside the mask hold their reset value forever.
`timescale 1ns/1ns
module fmg_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hff
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  output logic [7:0] value
);

  logic [7:0] value_ff;
  logic [7:0] nxt_value;

  always_comb begin
    nxt_value = value_ff;
    if (wrEn) begin
      nxt_value = (wrData & WR_MASK) | (RESET_VAL & ~WR_MASK);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      value_ff <= RESET_VAL;
    end else begin
      value_ff <= nxt_value;
    end
  end

  assign value = value_ff;

endmodule

/* hw/fmg_fault_gate.sv */
// Purpose: Turn rail faults into a shutdown request unless the rail is masked.
// Assumes: Fault inputs are synchronous levels from the rail monitors.
// Notes: Request is registered, so it follows a fault by one clock.
`timescale 1ns/1ns
module fmg_fault_gate (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [fmg_pkg::NUM_RAILS-1:0] railFault,
  input wire logic [7:0] maskFirst,
  input wire logic [7:0] maskSecond,
  output logic shutdownReq
);

  logic [fmg_pkg::NUM_RAILS-1:0] effMask;
  logic pairMasked;
  logic shutdown_ff;
  logic nxt_shutdown;

  always_comb begin
    // paired mask code
    // Reserved codes leave the pair unmasked, the safer reading.
    pairMasked = (maskSecond[fmg_pkg::BIT_PAIR_HI:fmg_pkg::BIT_PAIR_LO] == fmg_pkg::PAIR_MASKED);
    effMask = {maskSecond[fmg_pkg::BIT_ANALOG5_MASK], maskSecond[fmg_pkg::BIT_ADJ1_MASK],
               maskSecond[fmg_pkg::BIT_TERM_MASK], pairMasked,
               maskSecond[fmg_pkg::BIT_ADJ3_MASK], maskFirst};
    nxt_shutdown = |(railFault & ~effMask);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shutdown_ff <= 1'b0;
    end else begin
      shutdown_ff <= nxt_shutdown;
    end
  end

  assign shutdownReq = shutdown_ff;

  // Written from the register bits directly, so a slip in the mask vector shows up.
  property p_fault_shuts;
    @(posedge clock) disable iff (!rst_n)
    ((|(railFault[7:0] & ~maskFirst)) ||
     (railFault[fmg_pkg::FLT_ADJ3] && !maskSecond[fmg_pkg::BIT_ADJ3_MASK]) ||
     (railFault[fmg_pkg::FLT_TERM] && !maskSecond[fmg_pkg::BIT_TERM_MASK]) ||
     (railFault[fmg_pkg::FLT_ADJ1] && !maskSecond[fmg_pkg::BIT_ADJ1_MASK]) ||
     (railFault[fmg_pkg::FLT_ANALOG5] && !maskSecond[fmg_pkg::BIT_ANALOG5_MASK]))
    |=> shutdown_ff;
  endproperty
  a_fault_shuts: assert property (p_fault_shuts) else $error("Unmasked fault not passed.");

  property p_masked_quiet;
    @(posedge clock) disable iff (!rst_n)
    !(|(railFault & ~effMask)) |=> !shutdown_ff;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("Masked fault shut down.");

  property p_pair_code;
    @(posedge clock) disable iff (!rst_n)
    (railFault[fmg_pkg::FLT_PAIR] &&
     maskSecond[fmg_pkg::BIT_PAIR_HI:fmg_pkg::BIT_PAIR_LO] != fmg_pkg::PAIR_MASKED)
    |=> shutdown_ff;
  endproperty
  a_pair_code: assert property (p_pair_code) else $error("Paired fault not passed.");

  c_masked_fault: cover property (@(posedge clock) disable iff (!rst_n)
    (|(railFault & effMask)) ##1 !shutdown_ff);

endmodule

/* hw/fmg_reg_bank.sv */
// Purpose: Serial-port register bank for output pin level, rail fault masks and discharge.
// Assumes: Clock and data lines are synchronous to clock and far slower than it.
// Notes: Pointer auto-increments after each data byte; unmapped reads return zero.
`timescale 1ns/1ns
module fmg_reg_bank #(
  parameter logic [6:0] DEV_ADDR = fmg_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic gpoOut,
  output logic gpoOe,
  input wire logic [fmg_pkg::NUM_RAILS-1:0] railFault,
  output logic shutdownReq,
  output logic termDischargeEn
);

  fmg_pkg::fmg_state_t state_ff;
  fmg_pkg::fmg_state_t nxt_state;
  logic sclQ_ff;
  logic sdaQ_ff;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic [2:0] bitCnt_ff;
  logic [2:0] nxt_bitCnt;
  logic byteDone_ff;
  logic nxt_byteDone;
  logic rw_ff;
  logic nxt_rw;
  logic [7:0] ptr_ff;
  logic [7:0] nxt_ptr;
  logic sdaOe_ff;
  logic nxt_sdaOe;
  logic gpoOe_ff;
  logic nxt_gpoOe;
  logic termDis_ff;
  logic nxt_termDis;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic [3:0] regWe;
  logic [7:0] readByte;
  logic [7:0] pinCtrl;
  logic [7:0] maskFirst;
  logic [7:0] maskSecond;
  logic [7:0] dischCtrl;
  logic firstCycle_ff;

  // One-hot register select for the four offsets; zero when unmapped.
  function automatic logic [3:0] decodeReg(input logic [7:0] addr);
    decodeReg = {addr == fmg_pkg::OFS_DISCH, addr == fmg_pkg::OFS_MASK_SECOND,
                 addr == fmg_pkg::OFS_MASK_FIRST, addr == fmg_pkg::OFS_PIN_CTRL};
  endfunction

  fmg_byte_reg #(.RESET_VAL(fmg_pkg::RST_PIN_CTRL), .WR_MASK(fmg_pkg::WMASK_ALL)) uPinCtrl (
    .clock(clock),
    .rst_n(rst_n),
    .wrEn(regWe[0]),
    .wrData(shift_ff),
    .value(pinCtrl)
  );

  fmg_byte_reg #(.RESET_VAL(fmg_pkg::RST_MASK_FIRST), .WR_MASK(fmg_pkg::WMASK_ALL)) uMaskFirst (
    .clock(clock),
    .rst_n(rst_n),
    .wrEn(regWe[1]),
    .wrData(shift_ff),
    .value(maskFirst)
  );

  fmg_byte_reg #(.RESET_VAL(fmg_pkg::RST_MASK_SECOND), .WR_MASK(fmg_pkg::WMASK_SECOND))
    uMaskSecond (
    .clock(clock),
    .rst_n(rst_n),
    .wrEn(regWe[2]),
    .wrData(shift_ff),
    .value(maskSecond)
  );

  fmg_byte_reg #(.RESET_VAL(fmg_pkg::RST_DISCH), .WR_MASK(fmg_pkg::WMASK_ALL)) uDisch (
    .clock(clock),
    .rst_n(rst_n),
    .wrEn(regWe[3]),
    .wrData(shift_ff),
    .value(dischCtrl)
  );

  fmg_fault_gate uGate (
    .clock(clock),
    .rst_n(rst_n),
    .railFault(railFault),
    .maskFirst(maskFirst),
    .maskSecond(maskSecond),
    .shutdownReq(shutdownReq)
  );

  always_comb begin
    logic [3:0] sel;
    sel = decodeReg(ptr_ff);
    readByte = ({8{sel[0]}} & pinCtrl) | ({8{sel[1]}} & maskFirst) |
               ({8{sel[2]}} & maskSecond) | ({8{sel[3]}} & dischCtrl);
    sclRise = sclIn & ~sclQ_ff;
    sclFall = ~sclIn & sclQ_ff;
    startSeen = sclIn & sclQ_ff & sdaQ_ff & ~sdaIn;
    stopSeen = sclIn & sclQ_ff & ~sdaQ_ff & sdaIn;
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_byteDone = byteDone_ff;
    nxt_rw = rw_ff;
    nxt_ptr = ptr_ff;
    nxt_sdaOe = sdaOe_ff;
    regWe = 4'h0;
    nxt_gpoOe = ~pinCtrl[fmg_pkg::BIT_PIN_LEVEL];
    nxt_termDis = dischCtrl[fmg_pkg::BIT_TERM_DISCH];
    if (startSeen) begin
      nxt_state = fmg_pkg::ST_ADDR;
      nxt_bitCnt = 3'h0;
      nxt_byteDone = 1'b0;
      nxt_sdaOe = 1'b0;
    end else if (stopSeen) begin
      nxt_state = fmg_pkg::ST_IDLE;
      nxt_sdaOe = 1'b0;
    end else begin
      case (state_ff)
        fmg_pkg::ST_IDLE: begin
          nxt_sdaOe = 1'b0;
        end
        fmg_pkg::ST_ADDR, fmg_pkg::ST_PTR, fmg_pkg::ST_WDATA: begin
          if (sclRise) begin
            nxt_shift = {shift_ff[6:0], sdaIn};
            nxt_bitCnt = bitCnt_ff + 3'h1;
            nxt_byteDone = (bitCnt_ff == 3'h7);
          end else if (sclFall && byteDone_ff) begin
            nxt_byteDone = 1'b0;
            nxt_sdaOe = 1'b1;
            if (state_ff == fmg_pkg::ST_ADDR) begin
              nxt_rw = shift_ff[0];
              nxt_state = fmg_pkg::ST_ADDR_ACK;
              if (shift_ff[7:1] != DEV_ADDR) begin
                nxt_sdaOe = 1'b0;
                nxt_state = fmg_pkg::ST_IDLE;
              end
            end else if (state_ff == fmg_pkg::ST_PTR) begin
              nxt_ptr = shift_ff;
              nxt_state = fmg_pkg::ST_PTR_ACK;
            end else begin
              // Unmapped writes are acknowledged and dropped.
              regWe = decodeReg(ptr_ff);
              nxt_ptr = ptr_ff + 8'h01;
              nxt_state = fmg_pkg::ST_WDATA_ACK;
            end
          end
        end
        fmg_pkg::ST_ADDR_ACK, fmg_pkg::ST_RDATA_ACK: begin
          if (state_ff == fmg_pkg::ST_RDATA_ACK && sclRise) begin
            // A not-acknowledge ends the read; the host then stops or restarts.
            nxt_byteDone = ~sdaIn;
            if (sdaIn) begin
              nxt_state = fmg_pkg::ST_IDLE;
            end
          end else if (sclFall && rw_ff &&
                       (state_ff == fmg_pkg::ST_ADDR_ACK || byteDone_ff)) begin
            nxt_byteDone = 1'b0;
            nxt_shift = readByte;
            nxt_sdaOe = ~readByte[7];
            nxt_ptr = ptr_ff + 8'h01;
            nxt_bitCnt = 3'h0;
            nxt_state = fmg_pkg::ST_RDATA;
          end else if (sclFall && state_ff == fmg_pkg::ST_ADDR_ACK) begin
            nxt_sdaOe = 1'b0;
            nxt_bitCnt = 3'h0;
            nxt_state = fmg_pkg::ST_PTR;
          end
        end
        fmg_pkg::ST_PTR_ACK, fmg_pkg::ST_WDATA_ACK: begin
          if (sclFall) begin
            nxt_sdaOe = 1'b0;
            nxt_bitCnt = 3'h0;
            nxt_state = fmg_pkg::ST_WDATA;
          end
        end
        fmg_pkg::ST_RDATA: begin
          if (sclRise) begin
            nxt_bitCnt = bitCnt_ff + 3'h1;
            nxt_byteDone = (bitCnt_ff == 3'h7);
          end else if (sclFall) begin
            if (byteDone_ff) begin
              nxt_byteDone = 1'b0;
              nxt_sdaOe = 1'b0;
              nxt_state = fmg_pkg::ST_RDATA_ACK;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_sdaOe = ~shift_ff[6];
            end
          end
        end
        default: begin
          nxt_state = fmg_pkg::ST_IDLE;
          nxt_sdaOe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= fmg_pkg::ST_IDLE;
      sclQ_ff <= 1'b1;
      sdaQ_ff <= 1'b1;
      shift_ff <= 8'h00;
      bitCnt_ff <= 3'h0;
      byteDone_ff <= 1'b0;
      rw_ff <= 1'b0;
      ptr_ff <= 8'h00;
      sdaOe_ff <= 1'b0;
      gpoOe_ff <= 1'b0;
      termDis_ff <= 1'b0;
      firstCycle_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      sclQ_ff <= sclIn;
      sdaQ_ff <= sdaIn;
      shift_ff <= nxt_shift;
      bitCnt_ff <= nxt_bitCnt;
      byteDone_ff <= nxt_byteDone;
      rw_ff <= nxt_rw;
      ptr_ff <= nxt_ptr;
      sdaOe_ff <= nxt_sdaOe;
      gpoOe_ff <= nxt_gpoOe;
      termDis_ff <= nxt_termDis;
      firstCycle_ff <= 1'b0;
    end
  end

  // Both open-drain lines only ever pull low, so their data outputs stay zero.
  assign sdaOut = 1'b0;
  assign gpoOut = 1'b0;
  assign sdaOe = sdaOe_ff;
  assign gpoOe = gpoOe_ff;
  assign termDischargeEn = termDis_ff;

  property p_pin_follows;
    @(posedge clock) disable iff (!rst_n)
    !firstCycle_ff |-> (gpoOe_ff == !$past(pinCtrl[fmg_pkg::BIT_PIN_LEVEL]));
  endproperty
  a_pin_follows: assert property (p_pin_follows) else $error("Pin drive wrong.");

  property p_pin_reset;
    @(posedge clock) disable iff (!rst_n)
    firstCycle_ff |-> (pinCtrl == fmg_pkg::RST_PIN_CTRL && !gpoOe_ff);
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("Pin control reset value wrong.");

  property p_first_reset;
    @(posedge clock) disable iff (!rst_n)
    firstCycle_ff |-> (maskFirst == fmg_pkg::RST_MASK_FIRST);
  endproperty
  a_first_reset: assert property (p_first_reset) else $error("First mask reset wrong.");

  property p_rails_masked;
    @(posedge clock) disable iff (!rst_n)
    firstCycle_ff |-> (maskFirst[fmg_pkg::BIT_ADJ2_MASK] && maskFirst[fmg_pkg::BIT_LSW1_MASK] &&
                       maskFirst[5:0] == 6'h00);
  endproperty
  a_rails_masked: assert property (p_rails_masked) else $error("Reset mask pattern wrong.");

  property p_first_write;
    @(posedge clock) disable iff (!rst_n)
    regWe[1] |=> (maskFirst == $past(shift_ff));
  endproperty
  a_first_write: assert property (p_first_write) else $error("First mask write lost.");

  property p_second_reset;
    @(posedge clock) disable iff (!rst_n)
    firstCycle_ff |-> (maskSecond == fmg_pkg::RST_MASK_SECOND);
  endproperty
  a_second_reset: assert property (p_second_reset) else $error("Second mask reset wrong.");

  property p_second_ro;
    @(posedge clock) disable iff (!rst_n)
    regWe[2] |=> (maskSecond[fmg_pkg::BIT_SECOND_RO] == 1'b0) &&
                 (maskSecond[6:0] == $past(shift_ff[6:0]));
  endproperty
  a_second_ro: assert property (p_second_ro) else $error("Second mask write wrong.");

  property p_disch;
    @(posedge clock) disable iff (!rst_n)
    (firstCycle_ff |-> dischCtrl == fmg_pkg::RST_DISCH) and
    (!firstCycle_ff |-> termDis_ff == $past(dischCtrl[fmg_pkg::BIT_TERM_DISCH]));
  endproperty
  a_disch: assert property (p_disch) else $error("Discharge control wrong.");

  c_write: cover property (@(posedge clock) disable iff (!rst_n) |regWe);
  c_read: cover property (@(posedge clock) disable iff (!rst_n) state_ff == fmg_pkg::ST_RDATA_ACK);
  c_pin_low: cover property (@(posedge clock) disable iff (!rst_n) $rose(gpoOe_ff));

endmodule

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the fault mask, output pin and discharge bank.
// Assumes: Bench is the serial host; its lines change on the falling clock edge.
// Notes: A register model predicts every read, the pin, discharge and shutdown.
`timescale 1ns/1ns
module tb_top;
  localparam logic [6:0] ADDR = fmg_pkg::DEV_ADDR_DEFAULT;
  localparam logic [7:0] A1 = fmg_pkg::OFS_PIN_CTRL;
  localparam logic [7:0] A2 = fmg_pkg::OFS_MASK_FIRST;
  localparam logic [7:0] A3 = fmg_pkg::OFS_MASK_SECOND;
  localparam logic [7:0] AD = fmg_pkg::OFS_DISCH;
  logic clock;
  logic rst_n;
  logic sclIn;
  logic sdaM;
  logic sdaIn;
  logic sdaOut;
  logic sdaOe;
  logic gpoOut;
  logic gpoOe;
  logic shutdownReq;
  logic termDischargeEn;
  logic [fmg_pkg::NUM_RAILS-1:0] railFault;
  logic [7:0] regM [A1:AD];
  int errors;
  int n_compared;
  int cycles;

  // The data line is wired-AND: the host releases high, the device only pulls low.
  assign sdaIn = sdaM & ~sdaOe;

  fmg_reg_bank #(.DEV_ADDR(ADDR)) fmg_reg_bank_i (
    .clock(clock),
    .rst_n(rst_n),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .gpoOut(gpoOut),
    .gpoOe(gpoOe),
    .railFault(railFault),
    .shutdownReq(shutdownReq),
    .termDischargeEn(termDischargeEn)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // A hang ends the run with a counted mismatch.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic resetModel();
    for (int i = A1; i <= AD; i++) begin
      regM[i] = 8'h00;
    end
    regM[A1] = 8'h20;
    regM[A2] = 8'hc0;
    regM[A3] = 8'h37;
    regM[AD] = 8'h61;
  endtask

  function automatic logic expShut(input logic [12:0] f);
    logic [12:0] m;
    m = {regM[A3][5:3], regM[A3][2:1] == 2'b11, regM[A3][0], regM[A2]};
    return |(f & ~m);
  endfunction

  // Each line level holds at least two clocks, as the port requires.
  task automatic sendBit(input logic b);
    sclIn = 1'b0;
    tick(2);
    sdaM = b;
    tick(2);
    sclIn = 1'b1;
    tick(4);
  endtask

  task automatic recvBit(output logic b);
    sclIn = 1'b0;
    tick(2);
    sdaM = 1'b1;
    tick(2);
    sclIn = 1'b1;
    tick(2);
    b = sdaIn;
    tick(2);
  endtask

  task automatic startCond();
    sclIn = 1'b0;
    tick(2);
    sdaM = 1'b1;
    tick(2);
    sclIn = 1'b1;
    tick(4);
    sdaM = 1'b0;
    tick(4);
  endtask

  task automatic stopCond();
    sclIn = 1'b0;
    tick(2);
    sdaM = 1'b0;
    tick(2);
    sclIn = 1'b1;
    tick(4);
    sdaM = 1'b1;
    tick(4);
  endtask

  task automatic byteOut(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      sendBit(d[i]);
    end
    recvBit(b);
    ack = ~b;
  endtask

  task automatic regWrite(input logic [7:0] ofs, input logic [7:0] d);
    logic a0;
    logic a1;
    logic a2;
    startCond();
    byteOut({ADDR, 1'b0}, a0);
    byteOut(ofs, a1);
    byteOut(d, a2);
    stopCond();
    check({13'h0000, a0, a1, a2}, 16'h0007);
    if (ofs == A3) begin
      regM[ofs] = d & fmg_pkg::WMASK_SECOND;
    end else if (ofs == A1 || ofs == A2 || ofs == AD) begin
      regM[ofs] = d;
    end
    tick(4);
  endtask

  // Reads n bytes from one pointer; the pointer advances after each byte.
  task automatic readCheck(input logic [7:0] ofs, input int n);
    logic a0;
    logic a1;
    logic a2;
    logic [7:0] d;
    logic [7:0] p;
    startCond();
    byteOut({ADDR, 1'b0}, a0);
    byteOut(ofs, a1);
    startCond();
    byteOut({ADDR, 1'b1}, a2);
    check({13'h0000, a0, a1, a2}, 16'h0007);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        recvBit(d[i]);
      end
      sendBit(k == n - 1);
      p = ofs + 8'(k);
      check({8'h00, d}, {8'h00, (p >= A1 && p <= AD) ? regM[p] : 8'h00});
    end
    stopCond();
  endtask

  task automatic checkPins();
    check({11'h000, sdaOut, gpoOut, gpoOe, termDischargeEn, shutdownReq},
          {11'h000, 1'b0, 1'b0, ~regM[A1][5], regM[AD][4], expShut(railFault)});
  endtask

  task automatic faultSweep();
    for (int i = 0; i < fmg_pkg::NUM_RAILS; i++) begin
      railFault = 13'(1) << i;
      tick(3);
      checkPins();
    end
    railFault = 13'($urandom);
    tick(3);
    checkPins();
    railFault = '0;
    tick(3);
  endtask

  initial begin
    logic a;
    logic [7:0] rnd;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    sclIn = 1'b1;
    sdaM = 1'b1;
    railFault = '0;
    rst_n = 1'b0;
    resetModel();
    void'($urandom(32'h97a93ef4));
    tick(16);
    rst_n = 1'b1;
    tick(2);
    checkPins();
    readCheck(A1, 4);
    readCheck(AD, 1);
    faultSweep();
    // A foreign target address must go unanswered.
    startCond();
    byteOut({ADDR ^ 7'h01, 1'b0}, a);
    stopCond();
    check({15'h0000, a}, 16'h0000);
    for (int r = 0; r < 4; r++) begin
      // Software keeps reserved bits at reset and writes only legal pair codes.
      rnd = 8'($urandom);
      regWrite(A1, {2'b00, rnd[0], 5'h00});
      checkPins();
      regWrite(A2, 8'($urandom));
      regWrite(A3, {2'b00, rnd[5:3], {2{rnd[1]}}, rnd[2]});
      regWrite(AD, {3'b011, rnd[6], 4'h1});
      readCheck(A1, 3);
      readCheck(AD, 1);
      faultSweep();
    end
    // paired codes 0 and 3 only, other bits kept
    for (int c = 0; c < 4; c += 3) begin
      regWrite(A3, (regM[A3] & 8'hf9) | {5'h00, 2'(c), 1'b0});
      railFault = 13'(1) << fmg_pkg::FLT_PAIR;
      tick(3);
      checkPins();
      railFault = '0;
    end
    // both levels of each control bit
    for (int v = 0; v < 2; v++) begin
      regWrite(A1, {2'b00, 1'(v), 5'h00});
      checkPins();
      regWrite(AD, {3'b011, 1'(v), 4'h1});
      checkPins();
    end
    // Unmapped writes are dropped; the gap reads as zero.
    regWrite(8'ha5, 8'hff);
    readCheck(8'ha4, 2);
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    resetModel();
    tick(2);
    checkPins();
    readCheck(A1, 3);
    readCheck(AD, 1);
    conclude();
  end
endmodule
